// ===== logic/scc_pkg.sv
// Package for the SDRAM configuration and low-power control block.
package scc_pkg;

   // ==========================================================
   // Register map
   // ==========================================================
   localparam logic [11:0] SCC_CONFIG_OFFSET = 12'h000;
   localparam logic [11:0] SCC_STATUS_OFFSET = 12'h004;

   // ==========================================================
   // Field positions of sdram_configuration
   // ==========================================================
   localparam int SCC_SREF_BIT = 31;
   localparam int SCC_PDOWN_BIT = 30;
   localparam int SCC_DOWN_REF_BIT = 29;
   localparam int SCC_NARROW_BIT = 14;
   localparam int SCC_CL_LSB = 9;
   localparam int SCC_UNLOCK_BIT = 8;
   localparam int SCC_BANK_LSB = 4;
   localparam int SCC_PAGE_LSB = 0;
   localparam int SCC_UPPER_LANE = 3;

   // ==========================================================
   // Values after reset
   // ==========================================================
   localparam logic [2:0] SCC_CL_RESET = 3'h3;
   localparam logic [2:0] SCC_BANK_RESET = 3'h2;
   localparam logic [2:0] SCC_PAGE_RESET = 3'h0;

   // ==========================================================
   // Field codes
   // ==========================================================
   localparam logic [2:0] SCC_CL_TWO = 3'h2;
   localparam logic [2:0] SCC_CL_THREE = 3'h3;

   // ==========================================================
   // Types
   // ==========================================================
   // Stored configuration; the unlock bit is never stored.
   typedef struct packed {
      logic self_refresh_request;
      logic power_down_request;
      logic refresh_during_power_down;
      logic narrow_bus_select;
      logic [2:0] cas_latency_code;
      logic [2:0] bank_count_code;
      logic [2:0] column_width_code;
   } scc_cfg_s;

   // Low-power states, Gray coded along active, down, refresh, self.
   typedef enum logic [1:0] {
      SCC_LP_ACTIVE = 2'h0,
      SCC_LP_PDOWN = 2'h1,
      SCC_LP_PDREF = 2'h3,
      SCC_LP_SREF = 2'h2
   } scc_lp_e;

   // ==========================================================
   // Decoders
   // ==========================================================
   // Register image as software reads it; reserved and unlock read 0.
   function automatic logic [31:0] scc_image(input scc_cfg_s c);
      logic [31:0] v;
      v = 32'h0000_0000;
      v[SCC_SREF_BIT] = c.self_refresh_request;
      v[SCC_PDOWN_BIT] = c.power_down_request;
      v[SCC_DOWN_REF_BIT] = c.refresh_during_power_down;
      v[SCC_NARROW_BIT] = c.narrow_bus_select;
      v[SCC_CL_LSB +: 3] = c.cas_latency_code;
      v[SCC_BANK_LSB +: 3] = c.bank_count_code;
      v[SCC_PAGE_LSB +: 3] = c.column_width_code;
      return v;
   endfunction

   // Bank count: code 0,1,2 gives 1,2,4 banks; reserved codes give 0.
   function automatic logic [2:0] scc_banks(input logic [2:0] code);
      logic [2:0] n;
      n = 3'h0;
      if (code < 3'h3) begin
         n = 3'(4'h1 << code);
      end
      return n;
   endfunction

   // Column bits: code 0..3 gives 8..11; reserved codes give 0.
   function automatic logic [3:0] scc_columns(input logic [2:0] code);
      logic [3:0] n;
      n = 4'h0;
      if (code < 3'h4) begin
         n = 4'h8 + {1'b0, code};
      end
      return n;
   endfunction

   // Read latency in memory clock cycles; reserved codes give 0.
   function automatic logic [1:0] scc_latency(input logic [2:0] code);
      logic [1:0] n;
      n = 2'h0;
      if (code == SCC_CL_TWO || code == SCC_CL_THREE) begin
         n = code[1:0];
      end
      return n;
   endfunction

endpackage

// ===== logic/scc_lowpower_fsm.sv
// Low-power sequencer: power-down, self-refresh and refresh in power-down.
`timescale 1ns/1ps

module scc_lowpower_fsm (
   input wire logic clk,
   input wire logic reset,
   input wire logic self_refresh_request,
   input wire logic power_down_request,
   input wire logic refresh_during_power_down,
   input wire logic refresh_needed,
   output scc_pkg::scc_lp_e lp_state,
   output logic mem_cke,
   output logic auto_refresh
);

   // ==========================================================
   // Refresh demand edge
   // ==========================================================
   logic refresh_needed_q;
   logic refresh_rise;
   scc_pkg::scc_lp_e next_state;

   // A level that stays high must not cause a refresh every cycle.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refresh_needed_q <= 1'b0;
      end else begin
         refresh_needed_q <= refresh_needed;
      end
   end

   assign refresh_rise = refresh_needed & ~refresh_needed_q;

   // ==========================================================
   // Next state
   // ==========================================================
   // Self-refresh is checked first in every state, so it wins.
   always_comb begin
      next_state = lp_state;
      unique case (lp_state)
         scc_pkg::SCC_LP_ACTIVE: begin
            if (self_refresh_request) begin
               next_state = scc_pkg::SCC_LP_SREF;
            end else if (power_down_request) begin
               next_state = scc_pkg::SCC_LP_PDOWN;
            end
         end
         scc_pkg::SCC_LP_PDOWN: begin
            if (self_refresh_request) begin
               next_state = scc_pkg::SCC_LP_SREF;
            end else if (!power_down_request) begin
               next_state = scc_pkg::SCC_LP_ACTIVE;
            end else if (refresh_during_power_down && refresh_rise) begin
               next_state = scc_pkg::SCC_LP_PDREF;
            end
         end
         scc_pkg::SCC_LP_PDREF: begin
            if (self_refresh_request) begin
               next_state = scc_pkg::SCC_LP_SREF;
            end else if (power_down_request) begin
               next_state = scc_pkg::SCC_LP_PDOWN;
            end else begin
               next_state = scc_pkg::SCC_LP_ACTIVE;
            end
         end
         scc_pkg::SCC_LP_SREF: begin
            if (!self_refresh_request) begin
               next_state = power_down_request ? scc_pkg::SCC_LP_PDOWN
                                               : scc_pkg::SCC_LP_ACTIVE;
            end
         end
      endcase
   end

   // ==========================================================
   // State and registered memory-side outputs
   // ==========================================================
   // Outputs follow the next state so they line up with lp_state.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lp_state <= scc_pkg::SCC_LP_ACTIVE;
         mem_cke <= 1'b1;
         auto_refresh <= 1'b0;
      end else begin
         lp_state <= next_state;
         mem_cke <= next_state == scc_pkg::SCC_LP_ACTIVE ||
                    next_state == scc_pkg::SCC_LP_PDREF;
         auto_refresh <= next_state == scc_pkg::SCC_LP_PDREF;
      end
   end

endmodule

// ===== logic/scc_config_regs.sv
// SDRAM configuration register with APB slave and low-power control.
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps

// Behaviour
// - Writing 1 to bit 31 enters self-refresh, writing 0 leaves it.
// - Writing 1 to bit 30 enters power-down, writing 0 leaves it.
// - With both low-power bits set, self-refresh is entered.
// - With bit 29 set, each refresh demand in power-down refreshes.
// - Reserved bits 28-15, 13-12, 7 and 3 read as zero.
// - Bit 14 selects a 32-bit bus when 0 and 16-bit when 1.
// - Writes to the lower configuration fields start initialization.
// - Bits 11-9 hold CAS latency, code 2 or 3 giving that many cycles.
// - The latency changes only when bit 8 is written 1 alongside.
// - Bit 8 always reads back as zero.
// - Bits 6-4 give the bank count, codes 0,1,2 for 1,2,4 banks.
// - Bits 2-0 give column bits, codes 0 to 3 for 8 to 11 bits.
// - Any write reaching the lower three bytes starts initialization.
module scc_config_regs (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic refresh_needed,
   output logic init_start,
   output logic narrow_bus_select,
   output logic [1:0] cas_latency,
   output logic [2:0] bank_count,
   output logic [3:0] column_bits,
   output logic mem_cke,
   output logic auto_refresh,
   output logic self_refresh_active,
   output logic power_down_active
);

   // ==========================================================
   // Bus decode
   // ==========================================================
   scc_pkg::scc_cfg_s cfg;
   scc_pkg::scc_lp_e lp_state;
   logic setup_phase;
   logic wr_done;
   logic hit_config;
   logic hit_status;
   logic wr_config;
   logic lower_touched;
   logic [31:0] status_image;

   assign setup_phase = psel & ~penable;
   assign wr_done = psel & penable & pready & pwrite;
   assign hit_config = paddr == scc_pkg::SCC_CONFIG_OFFSET;
   assign hit_status = paddr == scc_pkg::SCC_STATUS_OFFSET;
   assign wr_config = wr_done & hit_config & ~pslverr;
   assign lower_touched = |pstrb[2:0];
   assign status_image = {29'h0, mem_cke, lp_state};

   // ==========================================================
   // APB answer
   // ==========================================================
   // Answer is computed in the setup cycle so the access phase is one
   // cycle long; the cost is that prdata is sampled from setup values.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~hit_config & ~hit_status;
         if (setup_phase && !pwrite && hit_config) begin
            prdata <= scc_pkg::scc_image(cfg);
         end else if (setup_phase && !pwrite && hit_status) begin
            prdata <= status_image;
         end else if (setup_phase) begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ==========================================================
   // Low-power bits in the upper byte
   // ==========================================================
   // self-refresh, power-down and refresh-in-power-down bits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg.self_refresh_request <= 1'b0;
         cfg.power_down_request <= 1'b0;
         cfg.refresh_during_power_down <= 1'b0;
      end else if (wr_config && pstrb[scc_pkg::SCC_UPPER_LANE]) begin
         cfg.self_refresh_request <= pwdata[scc_pkg::SCC_SREF_BIT];
         cfg.power_down_request <= pwdata[scc_pkg::SCC_PDOWN_BIT];
         cfg.refresh_during_power_down <= pwdata[scc_pkg::SCC_DOWN_REF_BIT];
      end
   end

   // ==========================================================
   // Geometry fields in the lower bytes
   // ==========================================================
   // upper-only leaves these
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg.narrow_bus_select <= 1'b0;
         cfg.bank_count_code <= scc_pkg::SCC_BANK_RESET;
         cfg.column_width_code <= scc_pkg::SCC_PAGE_RESET;
      end else if (wr_config) begin
         if (pstrb[1]) begin
            cfg.narrow_bus_select <= pwdata[scc_pkg::SCC_NARROW_BIT];
         end
         if (pstrb[0]) begin
            cfg.bank_count_code <= pwdata[scc_pkg::SCC_BANK_LSB +: 3];
            cfg.column_width_code <= pwdata[scc_pkg::SCC_PAGE_LSB +: 3];
         end
      end
   end

   // The lock keeps a stray lane-1 write from corrupting latency.
   // unlock gates latency
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg.cas_latency_code <= scc_pkg::SCC_CL_RESET;
      end else if (wr_config && pstrb[1] &&
                   pwdata[scc_pkg::SCC_UNLOCK_BIT]) begin
         cfg.cas_latency_code <= pwdata[scc_pkg::SCC_CL_LSB +: 3];
      end
   end

   // ==========================================================
   // Initialization trigger
   // ==========================================================
   // Written values do not matter: any lower-lane write restarts it.
   // lower write starts
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         init_start <= 1'b0;
      end else begin
         init_start <= wr_config & lower_touched;
      end
   end

   // ==========================================================
   // Decoded geometry outputs
   // ==========================================================
   // bus width, latency, bank and column decode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         narrow_bus_select <= 1'b0;
         cas_latency <= scc_pkg::scc_latency(scc_pkg::SCC_CL_RESET);
         bank_count <= scc_pkg::scc_banks(scc_pkg::SCC_BANK_RESET);
         column_bits <= scc_pkg::scc_columns(scc_pkg::SCC_PAGE_RESET);
      end else begin
         narrow_bus_select <= cfg.narrow_bus_select;
         cas_latency <= scc_pkg::scc_latency(cfg.cas_latency_code);
         bank_count <= scc_pkg::scc_banks(cfg.bank_count_code);
         column_bits <= scc_pkg::scc_columns(cfg.column_width_code);
      end
   end

   // ==========================================================
   // Low-power sequencer
   // ==========================================================
   // sequencer handles priority
   scc_lowpower_fsm u_scc_lowpower_fsm (
      .clk(clk),
      .reset(reset),
      .self_refresh_request(cfg.self_refresh_request),
      .power_down_request(cfg.power_down_request),
      .refresh_during_power_down(cfg.refresh_during_power_down),
      .refresh_needed(refresh_needed),
      .lp_state(lp_state),
      .mem_cke(mem_cke),
      .auto_refresh(auto_refresh)
   );

   // Mode flags are registered from the sequencer state.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         self_refresh_active <= 1'b0;
         power_down_active <= 1'b0;
      end else begin
         self_refresh_active <= lp_state == scc_pkg::SCC_LP_SREF;
         power_down_active <= lp_state == scc_pkg::SCC_LP_PDOWN;
      end
   end

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_lower_init;
      wr_config && lower_touched |=> init_start;
   endproperty
   a_lower_init: assert property (p_lower_init)
      else $error("Lower-lane write did not start initialization.");

   property p_upper_only;
      wr_config && !lower_touched |=> !init_start && $stable(cfg.bank_count_code)
         && $stable(cfg.column_width_code) && $stable(cfg.cas_latency_code);
   endproperty
   a_upper_only: assert property (p_upper_only)
      else $error("Upper-only write disturbed lower fields.");

   property p_field_init;
      wr_config && (pstrb[1] || pstrb[0]) |=> init_start;
   endproperty
   a_field_init: assert property (p_field_init)
      else $error("Field write did not start initialization.");

   property p_narrow_copy;
      wr_config && pstrb[1]
         |=> cfg.narrow_bus_select == $past(pwdata[scc_pkg::SCC_NARROW_BIT]);
   endproperty
   a_narrow_copy: assert property (p_narrow_copy)
      else $error("Bus width bit not stored.");

   property p_cl_locked;
      wr_config && !pwdata[scc_pkg::SCC_UNLOCK_BIT]
         |=> $stable(cfg.cas_latency_code);
   endproperty
   a_cl_locked: assert property (p_cl_locked)
      else $error("Latency changed without unlock.");

   property p_cl_unlock;
      wr_config && pstrb[1] && pwdata[scc_pkg::SCC_UNLOCK_BIT]
         |=> cfg.cas_latency_code == $past(pwdata[11:9]);
   endproperty
   a_cl_unlock: assert property (p_cl_unlock)
      else $error("Unlocked latency write not stored.");

   property p_read_zero;
      psel && penable && pready && !pwrite && hit_config
         |-> (prdata & 32'h1FFF_B188) == 32'h0000_0000;
   endproperty
   a_read_zero: assert property (p_read_zero)
      else $error("Reserved or unlock bit read nonzero.");

   property p_unlock_zero;
      pready && !pwrite |-> !prdata[scc_pkg::SCC_UNLOCK_BIT] || !hit_config;
   endproperty
   a_unlock_zero: assert property (p_unlock_zero)
      else $error("Unlock bit read back as one.");

   // Decoded from the code table itself, not from the shared decoder.
   property p_latency_map;
      ##1 cas_latency == ($past(cfg.cas_latency_code) == scc_pkg::SCC_CL_TWO
         ? 2'h2 : $past(cfg.cas_latency_code) == scc_pkg::SCC_CL_THREE
         ? 2'h3 : 2'h0);
   endproperty
   a_latency_map: assert property (p_latency_map)
      else $error("Latency output does not match code.");

   property p_sref_prio;
      (cfg.self_refresh_request && cfg.power_down_request) [*3]
         |-> ##[0:2] lp_state == scc_pkg::SCC_LP_SREF;
   endproperty
   a_sref_prio: assert property (p_sref_prio)
      else $error("Self-refresh lost to power-down.");

   property p_sref_exit;
      !cfg.self_refresh_request [*3] |-> lp_state != scc_pkg::SCC_LP_SREF;
   endproperty
   a_sref_exit: assert property (p_sref_exit)
      else $error("Self-refresh held after bit cleared.");

   property p_pd_enter;
      (!cfg.self_refresh_request && cfg.power_down_request
         && !cfg.refresh_during_power_down) [*3] |-> !mem_cke;
   endproperty
   a_pd_enter: assert property (p_pd_enter)
      else $error("Power-down not entered.");

   // Both low-power bits clear: the devices run with the clock enabled.
   property p_pd_exit;
      (!cfg.self_refresh_request && !cfg.power_down_request) [*3]
         |-> mem_cke && lp_state == scc_pkg::SCC_LP_ACTIVE;
   endproperty
   a_pd_exit: assert property (p_pd_exit)
      else $error("Power-down held after bits cleared.");

   property p_pd_refresh;
      lp_state == scc_pkg::SCC_LP_PDOWN && cfg.power_down_request
         && !cfg.self_refresh_request && cfg.refresh_during_power_down
         && refresh_needed && !$past(refresh_needed) |=> auto_refresh;
   endproperty
   a_pd_refresh: assert property (p_pd_refresh)
      else $error("No refresh during power-down.");

   c_sref: cover property (lp_state == scc_pkg::SCC_LP_SREF);
   c_pdref: cover property (auto_refresh);
   c_init: cover property (init_start);
   c_err: cover property (pslverr && pready);
   c_pdown: cover property (lp_state == scc_pkg::SCC_LP_PDOWN);

endmodule

// ===== verification/scc_sdram_model.sv
// Behavioural model of the SDRAM devices seen at the memory-side outputs.
`timescale 1ns/1ps

module scc_sdram_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic mem_cke,
   input wire logic auto_refresh,
   output int refresh_count,
   output int misuse_count
);
   // ==========================================================
   // Command observer
   // ==========================================================
   // A real device ignores commands while its clock enable is low, so a
   // refresh issued with the enable low would be lost; count it as misuse.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refresh_count <= 0;
         misuse_count <= 0;
      end else if (auto_refresh === 1'b1) begin
         refresh_count <= refresh_count + 1;
         if (mem_cke !== 1'b1) begin
            misuse_count <= misuse_count + 1;
         end
      end
   end
endmodule

// ===== verification/tb_top.sv
// Self-checking testbench for the SDRAM configuration register block.
`timescale 1ns/1ps

module tb_top;
   logic clk, reset, psel, penable, pwrite, refresh_needed, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, column_bits;
   logic pready, pslverr, init_start, narrow_bus_select, mem_cke;
   logic auto_refresh, self_refresh_active, power_down_active;
   logic [1:0] cas_latency;
   logic [2:0] bank_count;
   int mismatches, total_checks, init_count, refresh_count, misuse_count;

   scc_config_regs u_scc_config_regs (.clk(clk), .reset(reset),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .refresh_needed(refresh_needed),
      .init_start(init_start), .narrow_bus_select(narrow_bus_select),
      .cas_latency(cas_latency), .bank_count(bank_count),
      .column_bits(column_bits), .mem_cke(mem_cke),
      .auto_refresh(auto_refresh),
      .self_refresh_active(self_refresh_active),
      .power_down_active(power_down_active));
   scc_sdram_model u_scc_sdram_model (.clk(clk), .reset(reset),
      .mem_cke(mem_cke), .auto_refresh(auto_refresh),
      .refresh_count(refresh_count), .misuse_count(misuse_count));

   // ==========================================================
   // Clock, reset and monitors
   // ==========================================================
   // Clock at 200 MHz.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Initialization requests are pulses, so they are counted here.
   always @(posedge clk) begin
      if (init_start === 1'b1) init_count++;
   end

   // ==========================================================
   // Helpers
   // ==========================================================
   // Every comparison is counted; a mismatch is reported at once.
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // One APB transfer; the request holds until pready is sampled high.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 32'h1, 32'h0);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Write, then let the decoded and low-power outputs settle.
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      apb(1'b1, a, d, s);
      repeat (3) @(posedge clk);
   endtask
   task automatic rd_chk(input string n, input logic [11:0] a,
                         input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, 4'hF);
      chk(n, e, rd);
   endtask

   // ==========================================================
   // Scenarios
   // ==========================================================
   task automatic t_reset();
      rd_chk("cfg reset", 12'h000, 32'h0000_0620); // reset image
      chk("cl reset", 32'h3, {30'h0, cas_latency}); // latency
      chk("bank reset", 32'h4, {29'h0, bank_count}); // banks
      chk("col reset", 32'h8, {28'h0, column_bits}); // columns
   endtask
   // Reserved and unlock bits written 1 must read back as zero.
   task automatic t_fields();
      int b;
      b = init_count;
      wr(12'h000, 32'h1FFF_F59B, 4'hF); // reserved ones
      rd_chk("cfg masked", 12'h000, 32'h0000_4413);
      chk("narrow", 32'h1, {31'h0, narrow_bus_select}); // bus
      chk("init full", b + 1, init_count); // init start
      // Latency stays put without the unlock bit in the same write.
      wr(12'h000, 32'h0000_4613, 4'hF); // no unlock
      chk("cl locked", 32'h2, {30'h0, cas_latency}); // lock
      rd_chk("cfg locked", 12'h000, 32'h0000_4413); // lock
      chk("init locked", b + 2, init_count); // init start
   endtask
   // All eight codes of each field, reserved ones decoding to zero.
   task automatic t_codes();
      logic [2:0] c;
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         wr(12'h000, {17'h0, 1'b1, 2'h0, c, 1'b1, 1'b0, c, 1'b0, c}, 4'hF);
         chk("cl", (i == 2 || i == 3) ? i : 0, 32'(cas_latency));
         chk("bank", (i < 3) ? (1 << i) : 0, {29'h0, bank_count});
         chk("col", (i < 4) ? 8 + i : 0, {28'h0, column_bits});
      end
      wr(12'h000, 32'h0000_4513, 4'hF); // unlock to 2
   endtask
   // Lane 2 alone starts initialization; a bad address is refused.
   task automatic t_lanes();
      int b;
      b = init_count;
      wr(12'h000, 32'h0000_0000, 4'h4); // lane 2 only
      chk("init lane2", b + 1, init_count); // lower bytes
      rd_chk("cfg lane2", 12'h000, 32'h0000_4413); // lower bytes
      apb(1'b1, 12'h008, 32'hFFFF_FFFF, 4'hF); // unmapped
      chk("slverr", 32'h1, {31'h0, er}); // unmapped refused
   endtask
   // Upper-byte writes drive the low-power states without init.
   task automatic t_lowpower();
      int b;
      b = init_count;
      wr(12'h000, 32'h6000_0000, 4'h8); // upper byte only
      chk("pd", 32'h1, {31'h0, power_down_active}); // enter
      chk("cke pd", 32'h0, {31'h0, mem_cke}); // enter
      rd_chk("status pd", 12'h004, 32'h0000_0001); // enter
      rd_chk("cfg upper", 12'h000, 32'h6000_4413); // upper only
      chk("init upper", b, init_count); // no init
      // Power-down refresh on each rising refresh demand.
      refresh_needed <= 1'b1;
      repeat (6) @(posedge clk);
      refresh_needed <= 1'b0;
      repeat (3) @(posedge clk);
      chk("refresh", 32'h1, refresh_count); // refresh
      chk("misuse", 32'h0, misuse_count); // refresh
      chk("pd back", 32'h1, {31'h0, power_down_active}); // return
      wr(12'h000, 32'hC000_0000, 4'h8); // both bits
      chk("sr", 32'h1, {31'h0, self_refresh_active}); // priority
      rd_chk("status sr", 12'h004, 32'h0000_0002); // priority
      wr(12'h000, 32'h0000_0000, 4'h8); // both clear
      chk("sr exit", 32'h0, {31'h0, self_refresh_active}); // exit
      chk("pd exit", 32'h0, {31'h0, power_down_active}); // exit
      rd_chk("status act", 12'h004, 32'h0000_0004); // exit
      wr(12'h000, 32'h8000_0000, 4'h8); // self only
      chk("sr only", 32'h1, {31'h0, self_refresh_active}); // enter
      // Leaving self-refresh with only the power-down bit set.
      wr(12'h000, 32'h4000_0000, 4'h8); // down only
      chk("pd only", 32'h1, {31'h0, power_down_active}); // enter
      chk("cke pd only", 32'h0, {31'h0, mem_cke}); // enter
      chk("init lp", b, init_count); // no init
   endtask

   // ==========================================================
   // Run control
   // ==========================================================
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // The whole sequence needs about 150 cycles; 4000 means a hang.
   initial begin
      #20000;
      mismatches++;
      summarize();
   end
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      refresh_needed = 1'b0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_reset();
      t_fields();
      t_codes();
      t_lanes();
      t_lowpower();
      summarize();
   end
endmodule
